// >>> core/park_ctrl_pkg.sv
/*
 Package for the reset, fast-park and test-point control block: timing counts,
 state enumeration and the packed carriers used on the block's ports.
 Assumes a single 10 MHz system clock and a synchronous active-high reset.
*/
// Notes on behaviour
// - Rising reset release starts self-configuration
// - Outputs stay inactive while reset held low
// - Test points tristated during reset, pulldown
// - Sample test points 1.5 us after release
// - Sampled high test point selects test mode
// - Active-low fast park parks mirror array
package park_ctrl_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SAMPLE_DELAY_NS = 1500;
   // Approximate instant, rounded down to whole cycles
   localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS / CLK_PERIOD_NS < 1) ? 1 : SAMPLE_DELAY_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(SAMPLE_DELAY_CYC - 1);
   localparam int TP_W = 8;
   localparam logic [TP_W-1:0] TP_OE_N_RESET = 8'hff;
   localparam logic [TP_W-1:0] TP_OUT_RESET = 8'h00;
   localparam logic [TP_W-1:0] MODE_RESET = 8'h00;
   localparam logic [TP_W-1:0] TP_OE_N_DRIVE = 8'h00;
   localparam logic [TP_W-1:0] TP_SYNC_RESET = 8'h00;
   // Synchronisers start as power-on reset asserted, park released
   localparam logic [1:0] SYNC_POR_RESET = 2'h0;
   localparam logic [1:0] SYNC_PARK_RESET = 2'h3;

   typedef enum logic [2:0] {
      ST_HELD,
      ST_WAIT_SAMPLE,
      ST_CONFIG,
      ST_RUN,
      ST_PARKING,
      ST_PARKED
   } ctrl_state_t;

   // Test-point pins: input, output value, active-low output enable
   typedef struct packed {
      logic [TP_W-1:0] level;
   } tp_in_t;
   typedef struct packed {
      logic [TP_W-1:0] value;
      logic [TP_W-1:0] oe_n;
   } tp_out_t;
endpackage

// >>> core/park_ctrl.sv
/*
 Reset release, fast park and test-point mode selection for a display
 controller. The power-on reset, fast park and test-point pad levels all
 arrive from outside the clock domain and each passes two flip-flops before
 the sequencer looks at it. After the power-on reset rises the block pulses
 a configuration start, waits the sample interval with the test points
 tristated, captures them as the test-mode code and then drives them.
 A fast park request is latched until the power-on reset goes low again.
 Outputs all come straight from flip-flops.
 Assumes the test-point pads carry a weak pulldown outside this logic, so an
 open pin reads low; the pad cell turns value and active-low enable into the
 pin. CONFIG_DONE and PARK_DONE come from logic on the same clock, and RESET
 is synchronous and active high.
*/
module park_ctrl
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic POWER_ON_RESET_N,
   input wire logic FAST_PARK_N,
   input wire logic CONFIG_DONE,
   input wire logic PARK_DONE,
   input wire park_ctrl_pkg::tp_in_t TEST_POINT_IN,
   input wire logic [park_ctrl_pkg::TP_W-1:0] TEST_POINT_DATA,
   output park_ctrl_pkg::tp_out_t TEST_POINT_OUT,
   output logic CONFIG_START,
   output logic PARK_REQUEST,
   output logic FUNCTION_ACTIVE,
   output logic TEST_MODE_ACTIVE,
   output logic [park_ctrl_pkg::TP_W-1:0] TEST_MODE_SELECT
);
   import park_ctrl_pkg::*;

   // Synchroniser stages for the asynchronous pins
   logic [1:0] rst_sync;
   logic [1:0] park_sync;
   logic [TP_W-1:0] tp_meta;
   logic [TP_W-1:0] tp_sync;
   logic [1:0] next_rst_sync;
   logic [1:0] next_park_sync;
   logic [TP_W-1:0] next_tp_meta;
   logic [TP_W-1:0] next_tp_sync;

   // Sequencer state and registered outputs
   ctrl_state_t state;
   ctrl_state_t next_state;
   // Counts down the sample interval
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [TP_W-1:0] mode;
   logic [TP_W-1:0] next_mode;
   tp_out_t tp_out;
   tp_out_t next_tp_out;
   logic cfg_start;
   logic next_cfg_start;
   logic park_req;
   logic next_park_req;
   logic active;
   logic next_active;
   // Registered test-mode flag keeps the output straight from a flip-flop
   logic test_mode;
   logic next_test_mode;

   // Two-stage synchronisers; first stage feeds only the second
   // A metastable first stage must never fan out into the sequencer
   always_comb
   begin
      next_rst_sync = {rst_sync[0], POWER_ON_RESET_N};
      next_park_sync = {park_sync[0], FAST_PARK_N};
      next_tp_meta = TEST_POINT_IN.level;
      next_tp_sync = tp_meta;
   end

   // Synchroniser registers
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         rst_sync <= SYNC_POR_RESET;
         park_sync <= SYNC_PARK_RESET;
         tp_meta <= TP_SYNC_RESET;
         tp_sync <= TP_SYNC_RESET;
      end
      else
      begin
         rst_sync <= next_rst_sync;
         park_sync <= next_park_sync;
         tp_meta <= next_tp_meta;
         tp_sync <= next_tp_sync;
      end
   end

   // Sequencer: reset hold, sample wait, configuration, run and park
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_mode = mode;
      next_tp_out = tp_out;
      next_cfg_start = 1'b0;
      next_park_req = park_req;
      next_active = active;
      next_test_mode = test_mode;
      // Power-on reset low acts as a functional reset
      if (!rst_sync[1])
      begin
         next_state = ST_HELD;
         next_park_req = 1'b0;
         next_active = 1'b0;
         next_tp_out.oe_n = TP_OE_N_RESET;
         next_tp_out.value = TP_OUT_RESET;
         next_count = SAMPLE_CNT;
         // A stale test-mode code would read as active while held
         next_mode = MODE_RESET;
         next_test_mode = 1'b0;
      end
      else
      begin
         unique case (state)
            // Only reached here with the synchronised reset high
            ST_HELD:
            begin
               next_state = ST_WAIT_SAMPLE;
               next_count = SAMPLE_CNT;
               next_cfg_start = 1'b1;
            end
            // Count down the sample interval, pins still tristated
            ST_WAIT_SAMPLE:
            begin
               if (count == '0)
               begin
                  next_mode = tp_sync;
                  next_test_mode = |tp_sync;
                  next_tp_out.oe_n = TP_OE_N_DRIVE;
                  next_state = ST_CONFIG;
               end
               else
                  next_count = count - 1'b1;
            end
            // Wait for the configuration logic to finish
            ST_CONFIG:
            begin
               if (CONFIG_DONE)
               begin
                  next_state = ST_RUN;
                  next_active = 1'b1;
               end
            end
            // Normal operation until a park request
            ST_RUN:
               next_active = 1'b1;
            // Mirror array parking in progress
            ST_PARKING:
            begin
               if (PARK_DONE)
               begin
                  next_state = ST_PARKED;
                  next_active = 1'b0;
               end
            end
            // Parked and latched until power-on reset goes low
            ST_PARKED:
               next_active = 1'b0;
         endcase
         // pins driven as outputs once sampled
         // Value stays zero while a park left the pins tristated
         if (state != ST_HELD && state != ST_WAIT_SAMPLE && tp_out.oe_n == TP_OE_N_DRIVE)
            next_tp_out.value = TEST_POINT_DATA;
         // fast park overrides any running state
         // Park also wins the next state over CONFIG_DONE in the same cycle, but FUNCTION_ACTIVE still rises
         if (!park_sync[1] && state != ST_HELD && state != ST_PARKING && state != ST_PARKED)
         begin
            next_state = ST_PARKING;
            next_park_req = 1'b1;
         end
      end
   end

   // Sequencer registers; synchronous reset only
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         state <= ST_HELD;
         count <= SAMPLE_CNT;
         mode <= MODE_RESET;
         tp_out <= '{value: TP_OUT_RESET, oe_n: TP_OE_N_RESET};
         cfg_start <= 1'b0;
         park_req <= 1'b0;
         active <= 1'b0;
         test_mode <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         mode <= next_mode;
         tp_out <= next_tp_out;
         cfg_start <= next_cfg_start;
         park_req <= next_park_req;
         active <= next_active;
         test_mode <= next_test_mode;
      end
   end

   // Outputs straight from flip-flops
   assign TEST_POINT_OUT = tp_out;
   assign CONFIG_START = cfg_start;
   assign PARK_REQUEST = park_req;
   // Run indication; the test modes themselves lie outside this block
   assign FUNCTION_ACTIVE = active;
   // any sampled high bit selects test mode
   assign TEST_MODE_ACTIVE = test_mode;
   assign TEST_MODE_SELECT = mode;
endmodule

// >>> sim/park_ctrl_checker.sv
/* Checker for park_ctrl ports, bound into park_ctrl.
 Assumes SYS_CLK only and RESET sync high. */
module park_ctrl_checker
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic POWER_ON_RESET_N,
   input wire logic FAST_PARK_N,
   input wire logic PARK_DONE,
   input wire logic [7:0] TEST_POINT_DATA,
   input wire park_ctrl_pkg::tp_out_t TEST_POINT_OUT,
   input wire logic CONFIG_START,
   input wire logic PARK_REQUEST,
   input wire logic FUNCTION_ACTIVE,
   input wire logic TEST_MODE_ACTIVE,
   input wire logic [7:0] TEST_MODE_SELECT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   wire logic drv = TEST_POINT_OUT.oe_n == 8'h00;
   start_pulse_a: assert property ($rose(POWER_ON_RESET_N) |-> ##[2:4] CONFIG_START) else $error("no start");
   start_once_a: assert property (CONFIG_START |=> !CONFIG_START) else $error("long start");
   held_quiet_a: assert property ((!POWER_ON_RESET_N)[*5] |-> TEST_POINT_OUT == 16'h00ff
      && !CONFIG_START && !PARK_REQUEST && !FUNCTION_ACTIVE && !TEST_MODE_ACTIVE) else $error("active in reset");
   sample_time_a: assert property (CONFIG_START |-> (TEST_POINT_OUT.oe_n == 8'hff)[*8] ##[5:10] drv)
      else $error("sample late");
   mode_flag_a: assert property (TEST_MODE_ACTIVE == (|TEST_MODE_SELECT)) else $error("bad mode");
   mode_hold_a: assert property (drv && $past(drv) |-> $stable(TEST_MODE_SELECT)) else $error("mode moved");
   drive_data_a: assert property (drv && $past(drv) |-> TEST_POINT_OUT.value == $past(TEST_POINT_DATA))
      else $error("bad drive");
   park_req_a: assert property ($fell(FAST_PARK_N) && FUNCTION_ACTIVE |-> ##[2:4] PARK_REQUEST)
      else $error("no park");
   park_stop_a: assert property (PARK_DONE && PARK_REQUEST |=> !FUNCTION_ACTIVE) else $error("run on");
   cover property (CONFIG_START);
   cover property (PARK_REQUEST);
   cover property (TEST_MODE_ACTIVE);
endmodule
bind park_ctrl park_ctrl_checker chk (.*);

// >>> sim/pmic_model.sv
/* Power chip model driving reset and park pins.
 Assumes the bench says when supplies are stable. */
module pmic_model
(
   input wire logic clk,
   input wire logic up,
   input wire logic park,
   output logic por_n = 1'b0,
   output logic park_n = 1'b1,
   output logic factory_test_enable,
   output logic test_port_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   // release and park on command only
   always @(posedge clk)
   begin
      por_n <= up;
      park_n <= !park;
   end
   assign factory_test_enable = 1'b0;
   assign test_port_reset_n = 1'b0;
endmodule

// >>> sim/park_ctrl_test.sv
/* Bench for park_ctrl: boot, test-mode sample, park.
 Assumes pads pulled down unless ext drives them. */
module park_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import park_ctrl_pkg::*;
   logic clk = 0, rst = 1, up = 0, park = 0, cdone = 0, pdone = 0, por_n, park_n, cs, pr, fa, tma;
   logic [7:0] data = 8'h5a, ext = 8'h00, tms;
   tp_out_t tpo;
   tp_in_t tpi;
   int mismatches = 0, check_count = 0;
   // pad level: driver wins, else ext
   assign tpi.level = (tpo.value & ~tpo.oe_n) | (ext & tpo.oe_n);
   initial forever #50 clk = ~clk;
   pmic_model pm (.clk(clk), .up(up), .park(park), .por_n(por_n), .park_n(park_n),
      .factory_test_enable(), .test_port_reset_n());
   park_ctrl dut (.SYS_CLK(clk), .RESET(rst), .POWER_ON_RESET_N(por_n), .FAST_PARK_N(park_n),
      .CONFIG_DONE(cdone), .PARK_DONE(pdone), .TEST_POINT_IN(tpi), .TEST_POINT_DATA(data),
      .TEST_POINT_OUT(tpo), .CONFIG_START(cs), .PARK_REQUEST(pr), .FUNCTION_ACTIVE(fa),
      .TEST_MODE_ACTIVE(tma), .TEST_MODE_SELECT(tms));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task quiet;
      chk(tpo.oe_n, 8'hff);
      chk(tpo.value, 8'h00);
      chk({5'h00, cs, pr, fa}, 8'h00);
      chk({7'h00, tma}, 8'h00);
      chk(tms, 8'h00);
   endtask
   task refuse_park;
      park = 1;
      cyc(6);
      quiet();
      park = 0;
      cyc(4);
   endtask
   task boot(input logic [7:0] sel);
      int n;
      ext = sel;
      up = 1;
      n = 0;
      while (cs !== 1'b1 && n < 30)
      begin
         cyc(1);
         n++;
      end
      chk({7'h00, cs}, 8'h01);
      cyc(12);
      chk(tpo.oe_n, 8'hff);
      cyc(8);
      ext = 8'h00;
      chk(tpo.oe_n, 8'h00);
      chk(tms, sel);
      chk({7'h00, tma}, {7'h00, |sel});
      chk(tpo.value, data);
      cdone = 1;
      cyc(1);
      cdone = 0;
      cyc(1);
      chk({7'h00, fa}, 8'h01);
   endtask
   task park_off;
      int n;
      park = 1;
      n = 0;
      while (pr !== 1'b1 && n < 10)
      begin
         cyc(1);
         n++;
      end
      chk({7'h00, pr}, 8'h01);
      pdone = 1;
      cyc(1);
      pdone = 0;
      cyc(1);
      chk({7'h00, fa}, 8'h00);
      up = 0;
      park = 0;
      cyc(6);
      quiet();
   endtask
   // Main sequence
   initial
   begin
      cyc(20);
      rst = 0;
      cyc(5);
      quiet();
      refuse_park();
      boot(8'h00);
      park_off();
      data = 8'ha5;
      boot(8'h24);
      park_off();
      print_verdict();
   end
   // Watchdog: a hang counts as failure
   initial
   begin
      #100000;
      mismatches++;
      print_verdict();
   end
endmodule
